// *** hdl/cam_host_ctrl.sv ***
// Host controller for a strobe-framed 4K x 32 CAM: runs control, status and setup cycles.
// Assumes the device samples controls at the strobe fall and the data bus pins resolve outside.
// Contract
// - Flags from last compare survive comparand loads
// - Host selects one device after random access
// - Reserved bits written as zero
// - Host writes whole VP table before enabling
// - Read with address flag high returns status
`timescale 1ns/1ps
module cam_host_ctrl
  import cam_host_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        i_core_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_ce,
  // Software register port
  input  wire logic [3:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic [31:0]      o_reg_rdata,
  // Device control pins
  output cam_ctrl_t        o_ctrl,
  output logic             o_validity_line_n,
  output logic             o_validity_oe,
  input  wire logic        i_validity_line_n,
  // Device data bus
  output logic [31:0]      o_data_bus,
  output logic             o_data_bus_oe,
  input  wire logic [31:0] i_data_bus,
  // Device result pins
  input  wire logic [3:0]  i_page_out,
  input  wire logic [11:0] i_active_addr_out,
  input  wire cam_flags_t  i_flags
);

  // ****************************************************************
  // Cycle state machine
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW  = 2'b01,
    ST_HIGH = 2'b11
  } cyc_state_t;

  cyc_state_t  state_r;
  logic [31:0] wdata_r;
  logic [31:0] opw_r;
  logic [31:0] rdata_r;
  logic [31:0] setup_r;
  logic [31:0] result_r;
  logic [6:0]  cmd_r;
  logic        err_r;
  logic        done_r;
  logic        start;
  logic        t_busy;
  logic        t_low;
  logic        t_rise;
  logic        t_done;
  logic        soft_mode;
  logic        cmd_wr;
  logic [2:0]  kind;

  assign cmd_wr    = i_reg_wr && (i_reg_addr == ADDR_CMD);
  assign start     = cmd_wr && (state_r == ST_IDLE);
  assign kind      = i_reg_wdata[CMD_KIND_LSB +: CMD_KIND_W];
  assign soft_mode = (setup_r[SETUP_MODE_LSB +: 2] == MODE_SOFT);

  cam_strobe_timer u_timer (
    .i_core_clk  (i_core_clk),
    .i_arst_n    (i_arst_n),
    .i_ce        (i_ce),
    .i_start     (start),
    .o_busy      (t_busy),
    .o_low_phase (t_low),
    .o_rise      (t_rise),
    .o_done      (t_done)
  );

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r <= ST_IDLE;
    end else if (i_ce) begin
      unique case (state_r)
        ST_IDLE: begin
          if (start) begin
            state_r <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (t_rise) begin
            state_r <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (t_done) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wdata_r <= '0;
      opw_r   <= '0;
      setup_r <= '0;
    end else if (i_ce && i_reg_wr) begin
      unique case (i_reg_addr)
        ADDR_WDATA: wdata_r <= i_reg_wdata;
        ADDR_OPW:   opw_r   <= {19'h0, i_reg_wdata[OPW_RD_BIT:0]};
        ADDR_SETUP: setup_r <= i_reg_wdata & ~SETUP_RSVD_MASK;
        default: ;
      endcase
    end
  end

  // Command latch; a command during a running cycle is dropped and flagged
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cmd_r <= '0;
      err_r <= 1'b0;
    end else if (i_ce) begin
      if (start) begin
        cmd_r <= i_reg_wdata[6:0];
      end
      if (cmd_wr && state_r != ST_IDLE) begin
        err_r <= 1'b1;
      end else if (i_reg_wr && i_reg_addr == ADDR_STAT && i_reg_wdata[1]) begin
        err_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  logic [2:0] ck;
  logic       is_rd;
  assign ck    = cmd_r[CMD_KIND_LSB +: CMD_KIND_W];
  assign is_rd = (ck == KIND_CTRL_RD) || (ck == KIND_STATUS_RD);

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ctrl            <= '{strobe_n: 1'b1, write_n: 1'b1, direct_addr_flag_n: 1'b1,
                             select_global_n: 1'b1, select_local_n: 1'b1, op_lines: 12'h000};
      o_data_bus        <= '0;
      o_data_bus_oe     <= 1'b0;
      o_validity_line_n <= 1'b1;
      o_validity_oe     <= 1'b0;
    end else if (i_ce) begin
      if (state_r == ST_IDLE && start) begin
        o_ctrl.strobe_n        <= 1'b0;
        o_ctrl.select_global_n <= ~i_reg_wdata[CMD_SEL_G_BIT];
        o_ctrl.select_local_n  <= ~i_reg_wdata[CMD_SEL_L_BIT];
        o_validity_line_n      <= i_reg_wdata[CMD_VB_BIT];
        o_ctrl.op_lines        <= soft_mode ? 12'h000 : opw_r[OPW_BITS-1:0];
        unique case (kind)
          KIND_CTRL_WR: begin
            o_ctrl.write_n            <= 1'b0;
            o_ctrl.direct_addr_flag_n <= soft_mode ? 1'b0 : 1'b1;
            o_data_bus                <= wdata_r;
            o_data_bus_oe             <= 1'b1;
            o_validity_oe             <= 1'b1;
          end
          KIND_CTRL_RD: begin
            o_ctrl.write_n            <= 1'b1;
            o_ctrl.direct_addr_flag_n <= soft_mode ? 1'b0 : 1'b1;
          end
          KIND_STATUS_RD: begin
            o_ctrl.write_n            <= 1'b1;
            o_ctrl.direct_addr_flag_n <= 1'b1;
          end
          KIND_OPW_LOAD: begin
            o_ctrl.write_n            <= 1'b0;
            o_ctrl.direct_addr_flag_n <= 1'b1;
            o_data_bus                <= opw_r;
            o_data_bus_oe             <= 1'b1;
          end
          KIND_SETUP_WR: begin
            o_ctrl.write_n            <= 1'b0;
            o_ctrl.direct_addr_flag_n <= 1'b1;
            o_data_bus                <= setup_r;
            o_data_bus_oe             <= 1'b1;
          end
          default: begin
            o_ctrl.write_n            <= 1'b1;
            o_ctrl.direct_addr_flag_n <= 1'b1;
          end
        endcase
      end else if (state_r == ST_LOW && t_rise) begin
        o_ctrl.strobe_n <= 1'b1;
      end else if (state_r == ST_HIGH && t_done) begin
        o_ctrl.write_n            <= 1'b1;
        o_ctrl.direct_addr_flag_n <= 1'b1;
        o_ctrl.select_global_n    <= 1'b1;
        o_ctrl.select_local_n     <= 1'b1;
        o_data_bus_oe             <= 1'b0;
        o_validity_oe             <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Read capture and result tracking
  // ****************************************************************
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_r <= '0;
      done_r  <= 1'b0;
    end else if (i_ce) begin
      if (state_r == ST_LOW && t_rise && is_rd) begin
        rdata_r <= (ck == KIND_STATUS_RD) ? (i_data_bus & RPT_VALID_MASK) : i_data_bus;
      end
      if (state_r == ST_HIGH && t_done) begin
        done_r <= 1'b1;
      end else if (i_reg_wr && i_reg_addr == ADDR_STAT && i_reg_wdata[0]) begin
        done_r <= 1'b0;
      end
    end
  end

  // Flags follow the latest compare even while the address bus shows something else
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      result_r <= 32'hf000_0000;
    end else if (i_ce) begin
      result_r <= '0;
      result_r[RPT_LOOKUP_BIT]                <= i_flags.lookup_hit_n;
      result_r[RPT_CAM_BIT]                   <= i_flags.cam_hit_n;
      result_r[RPT_MULTI_BIT]                 <= i_flags.multi_hit_n;
      result_r[RPT_FULL_BIT]                  <= i_flags.array_full_n;
      result_r[RPT_PAGE_LSB +: 4]             <= i_page_out;
      result_r[RPT_ADDR_LSB +: 12]            <= i_active_addr_out;
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_reg_rdata <= '0;
    end else if (i_ce) begin
      if (i_reg_rd) begin
        unique case (i_reg_addr)
          ADDR_WDATA:  o_reg_rdata <= wdata_r;
          ADDR_OPW:    o_reg_rdata <= opw_r;
          ADDR_RDATA:  o_reg_rdata <= rdata_r;
          ADDR_STAT:   o_reg_rdata <= {28'h0, soft_mode, (state_r != ST_IDLE), err_r, done_r};
          ADDR_RESULT: o_reg_rdata <= result_r;
          ADDR_SETUP:  o_reg_rdata <= setup_r;
          default:     o_reg_rdata <= '0;
        endcase
      end else begin
        o_reg_rdata <= '0;
      end
    end
  end

  logic unused_busy;
  logic unused_low;
  assign unused_busy = t_busy;
  assign unused_low  = t_low ^ i_validity_line_n;

endmodule // cam_host_ctrl

// *** hdl/cam_host_pkg.sv ***
// Package for the CAM host controller: register field layout, op codes, cycle timing.
// Assumes a single core clock and a CAM device reached through its strobe-framed pins.
package cam_host_pkg;

  // ****************************************************************
  // Own command register map (word addresses on the software port)
  // ****************************************************************
  localparam logic [3:0] ADDR_CMD        = 4'h0;
  localparam logic [3:0] ADDR_WDATA      = 4'h1;
  localparam logic [3:0] ADDR_OPW        = 4'h2;
  localparam logic [3:0] ADDR_RDATA      = 4'h3;
  localparam logic [3:0] ADDR_STAT       = 4'h4;
  localparam logic [3:0] ADDR_RESULT     = 4'h5;
  localparam logic [3:0] ADDR_SETUP      = 4'h6;

  // ****************************************************************
  // Command register fields
  // ****************************************************************
  localparam int CMD_KIND_LSB   = 0;
  localparam int CMD_KIND_W     = 3;
  localparam int CMD_SEL_G_BIT  = 4;
  localparam int CMD_SEL_L_BIT  = 5;
  localparam int CMD_VB_BIT     = 6;

  // Host cycle kinds
  localparam logic [2:0] KIND_CTRL_WR   = 3'h0;
  localparam logic [2:0] KIND_CTRL_RD   = 3'h1;
  localparam logic [2:0] KIND_STATUS_RD = 3'h2;
  localparam logic [2:0] KIND_OPW_LOAD  = 3'h3;
  localparam logic [2:0] KIND_SETUP_WR  = 3'h4;

  // ****************************************************************
  // Device operating_setup fields
  // ****************************************************************
  localparam int SETUP_MASK_SEL_LSB = 29;
  localparam int SETUP_MODE_LSB     = 26;
  localparam int SETUP_LAST_BIT     = 25;
  localparam int SETUP_VP_DIS_BIT   = 24;
  localparam int SETUP_VP_MASK_LSB  = 12;
  localparam int SETUP_VP_PAGE_LSB  = 4;
  localparam int SETUP_DEV_PAGE_LSB = 0;
  localparam logic [1:0] MODE_SOFT  = 2'h3;
  localparam logic [31:0] SETUP_RSVD_MASK = 32'h1000_0f00;

  // ****************************************************************
  // Device result_report fields
  // ****************************************************************
  localparam int RPT_LOOKUP_BIT = 31;
  localparam int RPT_CAM_BIT    = 30;
  localparam int RPT_MULTI_BIT  = 29;
  localparam int RPT_FULL_BIT   = 28;
  localparam int RPT_TYPE_LSB   = 24;
  localparam int RPT_PAGE_LSB   = 16;
  localparam int RPT_ADDR_LSB   = 0;
  localparam logic [31:0] RPT_VALID_MASK = 32'hf30f_0fff;

  // Operation word: low 12 bits are op lines, bit 12 is the read flag
  localparam int OPW_BITS   = 12;
  localparam int OPW_RD_BIT = 12;

  // ****************************************************************
  // Cycle timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS   = 25;
  localparam int STROBE_LOW_NS   = 50;
  localparam int STROBE_HIGH_NS  = 50;
  localparam int STROBE_LOW_CYC  = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W           = 4;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic        strobe_n;
    logic        write_n;
    logic        direct_addr_flag_n;
    logic        select_global_n;
    logic        select_local_n;
    logic [11:0] op_lines;
  } cam_ctrl_t;

  typedef struct packed {
    logic lookup_hit_n;
    logic cam_hit_n;
    logic multi_hit_n;
    logic array_full_n;
  } cam_flags_t;

endpackage

// *** hdl/cam_strobe_timer.sv ***
// Strobe timer: frames one device cycle as a low phase then a high phase.
// Assumes i_start comes only while o_busy is low.
`timescale 1ns/1ps
module cam_strobe_timer
  import cam_host_pkg::*;
(
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_arst_n,
  input  wire logic i_ce,
  // Control
  input  wire logic i_start,
  output logic      o_busy,
  output logic      o_low_phase,
  output logic      o_rise,
  output logic      o_done
);

  localparam logic [CNT_W-1:0] LOW_LAST  = CNT_W'(STROBE_LOW_CYC - 1);
  localparam logic [CNT_W-1:0] HIGH_LAST = CNT_W'(STROBE_HIGH_CYC - 1);

  logic [CNT_W-1:0] cnt_r;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_r       <= '0;
      o_busy      <= 1'b0;
      o_low_phase <= 1'b0;
      o_rise      <= 1'b0;
      o_done      <= 1'b0;
    end else if (i_ce) begin
      o_rise <= 1'b0;
      o_done <= 1'b0;
      if (!o_busy) begin
        if (i_start) begin
          o_busy      <= 1'b1;
          o_low_phase <= 1'b1;
          cnt_r       <= '0;
        end
      end else if (o_low_phase) begin
        if (cnt_r == LOW_LAST) begin
          o_low_phase <= 1'b0;
          o_rise      <= 1'b1;
          cnt_r       <= '0;
        end else begin
          cnt_r <= cnt_r + CNT_W'(1);
        end
      end else if (cnt_r == HIGH_LAST) begin
        o_busy <= 1'b0;
        o_done <= 1'b1;
      end else begin
        cnt_r <= cnt_r + CNT_W'(1);
      end
    end
  end

endmodule // cam_strobe_timer

// *** sim/cam_host_ctrl_asserts.sv ***
// Port checker for the CAM host controller, one clock domain.
// Bound onto cam_host_ctrl from the testbench top file.
`timescale 1ns/1ps
module cam_host_ctrl_asserts
  import cam_host_pkg::*;
(
  // Clock and reset
  input wire logic        i_core_clk,
  input wire logic        i_arst_n,
  // Register port
  input wire logic [3:0]  i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [31:0] o_reg_rdata,
  // Device pins
  input wire cam_ctrl_t   o_ctrl,
  input wire logic        o_validity_oe,
  input wire logic [31:0] o_data_bus,
  input wire logic        o_data_bus_oe
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  // Timer rise is registered again in the pin stage, so the low phase is one cycle past the count
  property p_low; $fell(o_ctrl.strobe_n) |-> !o_ctrl.strobe_n [*3] ##1 o_ctrl.strobe_n; endproperty
  a_low: assert property (p_low) else $error("strobe low phase length wrong");
  property p_cause; $fell(o_ctrl.strobe_n) |-> $past(i_reg_wr) && $past(i_reg_addr) == ADDR_CMD; endproperty
  a_cause: assert property (p_cause) else $error("strobe without a command");
  property p_hold; !o_ctrl.strobe_n && !$past(o_ctrl.strobe_n) |-> $stable(o_ctrl) && $stable(o_data_bus); endproperty
  a_hold: assert property (p_hold) else $error("controls moved in low phase");
  property p_stat; $fell(o_ctrl.strobe_n) && $past(i_reg_wdata[2:0]) == KIND_STATUS_RD
    |-> o_ctrl.direct_addr_flag_n && o_ctrl.write_n && !o_data_bus_oe; endproperty
  a_stat: assert property (p_stat) else $error("status read not a flag-high read");
  property p_crd; $fell(o_ctrl.strobe_n) && $past(i_reg_wdata[2:0]) == KIND_CTRL_RD
    |-> o_ctrl.write_n && !o_data_bus_oe; endproperty
  a_crd: assert property (p_crd) else $error("control read drives the bus");
  property p_cwr; $fell(o_ctrl.strobe_n) && $past(i_reg_wdata[2:0]) == KIND_CTRL_WR
    |-> (!o_ctrl.write_n && o_data_bus_oe) [*4]; endproperty
  a_cwr: assert property (p_cwr) else $error("control write not driven");
  property p_rel; $rose(o_ctrl.strobe_n) |-> ##2 o_ctrl.select_global_n && o_ctrl.select_local_n
    && o_ctrl.write_n && !o_data_bus_oe && !o_validity_oe; endproperty
  a_rel: assert property (p_rel) else $error("selects or drivers not released");
  property p_rd0; !$past(i_reg_rd) |-> o_reg_rdata == '0; endproperty
  a_rd0: assert property (p_rd0) else $error("read data outside its cycle");
endmodule // cam_host_ctrl_asserts

// *** sim/cam_dev_model.sv ***
// Behavioural CAM device: strobe-framed cycles, registers, array and VP table.
// Assumes its own control state codes; answers only when selected.
`timescale 1ns/1ps
module cam_dev_model
  import cam_host_pkg::*;
(
  // From the host
  input  wire cam_ctrl_t   i_ctrl,
  input  wire logic [31:0] i_data,
  input  wire logic        i_vb_n,
  // Answers
  output logic [31:0]      o_data,
  output logic [3:0]       o_page,
  output logic [11:0]      o_addr,
  output cam_flags_t       o_flags
);
  localparam logic [11:0] OP_LDCMP = 12'h001, OP_CMP = 12'h002, OP_SETUP = 12'h003;
  localparam logic [11:0] OP_WRNF = 12'h004, OP_VPWR = 12'h005, OP_RDHPM = 12'h006;
  logic [31:0] cmp_r, setup_r, sel_r, stat, mem [4096];
  logic        empty [4096], vp [4096];
  logic [1:0]  rtype;
  logic [11:0] vi;
  int          hit, nm, nvalid;
  // Type: 0 compare (match or miss), 1 memory access, 2 VP table, 3 reset
  assign stat = {o_flags, 2'b0, rtype, 4'h0, o_page, 4'h0, o_addr};
  initial begin
    setup_r = 32'h0100_0000;
    sel_r = 32'h0000_0100;
    rtype = 2'h3;
    {o_flags, o_page, o_addr} = '1;
    o_data = '0;
    nvalid = 0;
    foreach (empty[i]) empty[i] = 1'b1;
  end
  task automatic wr_free();
    for (int i = 0; i < 4096; i++) if (empty[i]) begin
      mem[i] = i_data;
      empty[i] = i_vb_n;
      nvalid += int'(!i_vb_n);
      {o_page, o_addr, rtype} = {setup_r[3:0], i[11:0], 2'h1};
      o_flags.array_full_n = (nvalid != 4096);
      return;
    end
  endtask
  task automatic compare();
    hit = -1;
    nm = 0;
    cmp_r = i_data;
    vi = i_data[31:20] & ~setup_r[23:12];
    for (int i = 4095; i >= 0; i--) if (!empty[i] && mem[i] == i_data) begin
      hit = i;
      nm++;
    end
    o_flags.cam_hit_n = (hit < 0);
    o_flags.multi_hit_n = (nm < 2);
    o_flags.lookup_hit_n = (hit < 0) && !(setup_r[25] && !setup_r[24] && vp[vi] === 1'b0);
    if (hit >= 0) {o_page, o_addr, rtype} = {setup_r[3:0], hit[11:0], 2'h0};
    else if (!o_flags.lookup_hit_n) {o_page, o_addr, rtype} = {setup_r[7:4], vi, 2'h2};
    else {o_page, o_addr, rtype} = {16'hffff, 2'h0};
  endtask
  always @(negedge i_ctrl.strobe_n) begin
    // Let the host's other pins settle before they are sampled
    #1;
    if (!i_ctrl.select_global_n || !i_ctrl.select_local_n || (!sel_r[8] && sel_r[3:0] == setup_r[3:0])) begin
      if (i_ctrl.write_n) o_data = (i_ctrl.op_lines == OP_RDHPM) ? mem[o_addr] : stat;
      else case (i_ctrl.op_lines)
        OP_LDCMP: cmp_r = i_data;
        OP_SETUP: setup_r = i_data;
        OP_VPWR: vp[i_data[31:20]] = i_data[0];
        OP_WRNF: wr_free();
        OP_CMP: compare();
        default: ;
      endcase
    end
  end
  // Released bus shows a changed pattern, never the old word
  always @(posedge i_ctrl.strobe_n) o_data = ~o_data;
endmodule // cam_dev_model

// *** sim/cam_registers_and_vp_lookup_tb.sv ***
// Testbench: CAM host controller driving the behavioural device model.
// Assumes the model's control state codes and a pulled-up validity line.
`timescale 1ns/1ps
module cam_registers_and_vp_lookup_tb;
  import cam_host_pkg::*;
  localparam logic [31:0] RM = 32'hf00f_0fff;
  logic        i_core_clk = 1'b0, i_arst_n = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0, rd_seen = 1'b0;
  logic [3:0]  i_reg_addr = '0, page;
  logic [31:0] i_reg_wdata = '0, o_reg_rdata, o_data_bus, dev_data, bus, last, v [5];
  logic [11:0] aa;
  logic        vb_n, vb_oe, dbus_oe;
  wire         vb_line = vb_oe ? vb_n : 1'b1;
  cam_ctrl_t   o_ctrl;
  cam_flags_t  flags;
  logic [63:0] q [$];
  int          error_cnt = 0, compares = 0, cycles = 0;
  assign bus = dbus_oe ? o_data_bus : dev_data;
  always #12.5 i_core_clk = ~i_core_clk;
  cam_host_ctrl uut (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_ce(1'b1), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .o_ctrl(o_ctrl), .o_validity_line_n(vb_n), .o_validity_oe(vb_oe), .i_validity_line_n(vb_line),
    .o_data_bus(o_data_bus), .o_data_bus_oe(dbus_oe), .i_data_bus(bus), .i_page_out(page),
    .i_active_addr_out(aa), .i_flags(flags));
  cam_dev_model dev (.i_ctrl(o_ctrl), .i_data(bus), .i_vb_n(vb_line), .o_data(dev_data), .o_page(page),
    .o_addr(aa), .o_flags(flags));
  function automatic logic [31:0] rpt(input logic [3:0] f, input logic [3:0] p, input logic [11:0] a);
    return {f, 8'h0, p, 4'h0, a};
  endfunction
  task automatic fail(input string m);
    error_cnt++;
    $display("MISMATCH t=%0t %s", $time, m);
  endtask
  task automatic tally_and_finish();
    $display("error_cnt=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_core_clk);
    i_reg_wr <= 1'b0;
  endtask
  // A zero care mask marks a poll that is not compared
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge i_core_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    q.push_back({e & m, m});
    @(posedge i_core_clk);
    i_reg_rd <= 1'b0;
    @(negedge i_core_clk);
    last = o_reg_rdata;
  endtask
  task automatic cyc(input logic [2:0] k, input logic [11:0] op, input logic [31:0] d, input logic [2:0] s);
    int n;
    wr(ADDR_OPW, {19'h0, k == KIND_CTRL_RD, op});
    wr(ADDR_WDATA, d);
    wr(ADDR_CMD, {25'h0, s, 1'b0, k});
    n = 0;
    do begin
      rd(ADDR_STAT, '0, '0);
      n++;
    end while (last[2] !== 1'b0 && n < 20);
    if (n == 20) fail("busy stuck");
  endtask
  always @(posedge i_core_clk) rd_seen <= i_reg_rd;
  always @(negedge i_core_clk) begin : mon
    logic [63:0] e;
    if (rd_seen) begin
      e = q.pop_front();
      if (e[31:0] !== '0) begin
        compares++;
        if ((o_reg_rdata & e[31:0]) !== e[63:32]) fail($sformatf("rdata %h exp %h", o_reg_rdata, e[63:32]));
      end
    end
  end
  always @(posedge i_core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      fail("timeout");
      tally_and_finish();
    end
  end
  initial begin
    void'($urandom(74));
    repeat (10) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    rd(ADDR_STAT, '0, '1);
    rd(4'hf, '0, '1);
    rd(ADDR_RESULT, RM, RM);
    wr(ADDR_SETUP, '1);
    rd(ADDR_SETUP, ~SETUP_RSVD_MASK, '1);
    wr(ADDR_SETUP, 32'h0c00_0000);
    rd(ADDR_STAT, 32'h8, 32'h8);
    wr(ADDR_SETUP, '0);
    wr(ADDR_OPW, '1);
    rd(ADDR_OPW, 32'h1fff, '1);
    cyc(KIND_CTRL_WR, dev.OP_SETUP, 32'h0300_00a5, 3'b001);
    for (int i = 0; i < 5; i++) begin
      v[i] = (i == 3) ? v[1] : $urandom;
      cyc(KIND_CTRL_WR, dev.OP_WRNF, v[i], {i == 4, 2'b01});
      rd(ADDR_RESULT, rpt(4'hf, 4'h5, i[11:0]), RM);
    end
    cyc(KIND_CTRL_WR, dev.OP_CMP, v[0], 3'b001);
    rd(ADDR_RESULT, rpt(4'h3, 4'h5, 12'h0), RM);
    cyc(KIND_CTRL_WR, dev.OP_CMP, v[1], 3'b001);
    rd(ADDR_RESULT, rpt(4'h1, 4'h5, 12'h1), RM);
    cyc(KIND_STATUS_RD, 12'h0, '0, 3'b001);
    rd(ADDR_RDATA, 32'h1005_0001, '1);
    cyc(KIND_CTRL_WR, dev.OP_LDCMP, $urandom, 3'b001);
    cyc(KIND_CTRL_RD, dev.OP_RDHPM, '0, 3'b001);
    rd(ADDR_RDATA, v[1], '1);
    cyc(KIND_CTRL_WR, dev.OP_CMP, v[2], 3'b000);
    rd(ADDR_RESULT, rpt(4'h1, 4'h5, 12'h1), RM);
    for (int j = 0; j < 4096; j++) cyc(KIND_CTRL_WR, dev.OP_VPWR, {j[11:0], 19'h0, j != 'h0a0}, 3'b001);
    wr(ADDR_SETUP, 32'h0200_f0a5);
    cyc(KIND_SETUP_WR, dev.OP_SETUP, '0, 3'b001);
    cyc(KIND_CTRL_WR, dev.OP_CMP, 32'h0a70_0000, 3'b001);
    rd(ADDR_RESULT, rpt(4'h7, 4'ha, 12'h0a0), RM);
    cyc(KIND_CTRL_WR, dev.OP_CMP, 32'h0b00_0000, 3'b001);
    rd(ADDR_RESULT, RM, RM);
    cyc(KIND_CTRL_WR, dev.OP_CMP, v[0], 3'b001);
    rd(ADDR_RESULT, rpt(4'h3, 4'h5, 12'h0), RM);
    tally_and_finish();
  end
endmodule // cam_registers_and_vp_lookup_tb
bind cam_host_ctrl cam_host_ctrl_asserts u_chk (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .o_ctrl(o_ctrl), .o_validity_oe(o_validity_oe), .o_data_bus(o_data_bus),
  .o_data_bus_oe(o_data_bus_oe));
